//--- dv/tb.sv
/*
  Self-checking bench: software commands over APB reach the controller end
  through the host end. Assumes both ends share one clock and one clock enable.
*/
`include "vout_limit_consts.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic pready, pslverr, se, ev, alert;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, x;
  logic [1:0] en = 2'b11, ovd = 2'b00, chon;
  logic [7:0] tgt_a, tgt_b, tha, thb;
  logic [15:0] rv;
  int fail_count = 0, checked = 0, cyc = 0;
  limit_link_if limit_link_if_inst();
  limit_host limit_host_inst (.clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .lk(limit_link_if_inst.host));
  vout_limit_regs vout_limit_regs_inst (.clk(clk), .rst(rst), .ce(ce),
    .lk(limit_link_if_inst.device), .channel_enable_pins(en), .ov_detect(ovd),
    .channel_on(chon), .target_a(tgt_a), .target_b(tgt_b), .ov_threshold_code_a(tha),
    .ov_threshold_code_b(thb), .host_alert_out(alert));
  vout_limit_props vout_limit_props_inst (.clk(clk), .rst(rst),
    .req(limit_link_if_inst.req), .write(limit_link_if_inst.write),
    .word(limit_link_if_inst.word), .code(limit_link_if_inst.code),
    .wdata(limit_link_if_inst.wdata), .ack(limit_link_if_inst.ack),
    .err(limit_link_if_inst.err), .rdata(limit_link_if_inst.rdata));

  // The clock toggles every half period; a hang is cut short here.
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      test_done();
    end
  end

  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  // Prints the verdict and ends the run.
  task automatic test_done();
    if (fail_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Compares a seen value with an expected one.
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    x = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One link command; the answer lands in rv and the refusal flag in ev.
  task automatic op(input logic [7:0] c, input logic w, input logic wd, input logic [15:0] d);
    apb(1'b1, `HOST_WDATA_ADDR, {16'h0000, d});
    apb(1'b1, `HOST_CMD_ADDR, {22'h000000, wd, w, c});
    do apb(1'b0, `HOST_STAT_ADDR, 32'h0); while (x[`STAT_BUSY_BIT] !== 1'b0);
    ev = x[`STAT_ERR_BIT];
    apb(1'b0, `HOST_RDATA_ADDR, 32'h0);
    rv = x[15:0];
  endtask

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  // Per-page ceilings, derived thresholds, refused byte access, both pages.
  task automatic t_ceiling();
    op(`CMD_PAGE, 1, 0, 16'h0000);
    op(`CMD_OUTPUT_CEILING, 1, 1, 16'h0040);
    op(`CMD_PAGE, 1, 0, 16'h0001);
    op(`CMD_OUTPUT_CEILING, 1, 1, 16'h0050);
    op(`CMD_OUTPUT_CEILING, 0, 1, 16'h0000);
    chk("ceiling_b", rv, 16'h0050);
    op(`CMD_PAGE, 1, 0, 16'h0000);
    op(`CMD_OUTPUT_CEILING, 0, 1, 16'h0000);
    chk("ceiling_a", rv, 16'h0040);
    op(`CMD_OV_THRESHOLD, 0, 1, 16'h0000);
    chk("thr_read", rv, {8'h00, 8'h40 + `OV_OFFSET_DEFAULT});
    chk("thr_b", {8'h00, thb}, {8'h00, 8'h50 + `OV_OFFSET_DEFAULT});
    op(`CMD_OUTPUT_CEILING, 1, 0, 16'h0077);
    chk("ceil_byte_err", {15'h0, ev}, 16'h0001);
    op(`CMD_PAGE, 1, 0, 16'h00FF);
    op(`CMD_OUTPUT_CEILING, 1, 1, 16'h0060);
    repeat (3) @(posedge clk);
    chk("thr_both_a", {8'h00, tha}, {8'h00, 8'h60 + `OV_OFFSET_DEFAULT});
    chk("thr_both_b", {8'h00, thb}, {8'h00, 8'h60 + `OV_OFFSET_DEFAULT});
  endtask

  // Fine resolution forces the threshold; threshold writes are refused.
  task automatic t_fine();
    op(`CMD_DAC_RES, 1, 0, 16'h0001);
    op(`CMD_OV_THRESHOLD, 0, 1, 16'h0000);
    chk("thr_fine", rv, 16'h00FF);
    op(`CMD_OV_THRESHOLD, 1, 1, 16'h0011);
    chk("thr_write_err", {15'h0, ev}, 16'h0001);
    op(`CMD_DAC_RES, 1, 0, 16'h0000);
    repeat (3) @(posedge clk);
    chk("thr_coarse", {8'h00, tha}, {8'h00, 8'h60 + `OV_OFFSET_DEFAULT});
  endtask

  // The action register reads the same on both pages and refuses the rest.
  task automatic t_action();
    for (int p = 0; p < 2; p++) begin
      op(`CMD_PAGE, 1, 0, 16'(p));
      op(`CMD_OV_ACTION, 0, 0, 16'h0000);
      chk("action", rv, {8'h00, `OV_ACTION_LATCH});
    end
    op(`CMD_OV_ACTION, 0, 1, 16'h0000);
    chk("action_word_err", {15'h0, ev}, 16'h0001);
    op(`CMD_OV_ACTION, 1, 0, 16'h00BA);
    op(`CMD_OV_ACTION, 0, 0, 16'h0000);
    chk("action_kept", rv, 16'h0080);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped_err", {15'h0, se}, 16'h0001);
  endtask

  // Commands above the ceiling are clamped, warned and alerted unless masked.
  task automatic t_clamp();
    op(`CMD_PAGE, 1, 0, 16'h0000);
    op(`CMD_VOUT_COMMAND, 1, 1, 16'h0070);
    repeat (4) @(posedge clk);
    chk("target_a", {8'h00, tgt_a}, 16'h0060);
    chk("warn_alert", {15'h0, alert}, 16'h0001);
    op(`CMD_STATUS_VOUT, 0, 0, 16'h0000);
    chk("sv_minmax", {15'h0, rv[`SV_MINMAX_BIT]}, 16'h0001);
    op(`CMD_STATUS_BYTE, 0, 0, 16'h0000);
    chk("sb_other", {15'h0, rv[`SB_OTHER_BIT]}, 16'h0001);
    op(`CMD_STATUS_WORD, 0, 1, 16'h0000);
    chk("sw_vout", {15'h0, rv[15]}, 16'h0001);
    op(`CMD_CLEAR_FAULTS, 1, 0, 16'h0000);
    op(`CMD_ALERT_MASK, 1, 0, 16'h0008);
    op(`CMD_VOUT_COMMAND, 1, 1, 16'h0070);
    repeat (4) @(posedge clk);
    chk("masked_alert", {15'h0, alert}, 16'h0000);
    op(`CMD_PAGE, 1, 0, 16'h0001);
    op(`CMD_MARGIN_HIGH, 1, 1, 16'h0070);
    op(`CMD_OPERATION, 1, 0, 16'h00A0);
    repeat (4) @(posedge clk);
    chk("target_b", {8'h00, tgt_b}, 16'h0060);
    op(`CMD_OPERATION, 1, 0, 16'h0080);
  endtask

  // An overvoltage on one channel latches it off until its pin toggles.
  task automatic t_ov();
    op(`CMD_PAGE, 1, 0, 16'h0000);
    op(`CMD_CLEAR_FAULTS, 1, 0, 16'h0000);
    ce <= 1'b0;
    ovd <= 2'b01;
    repeat (10) @(posedge clk);
    chk("ce_frozen", {14'h0, chon}, 16'h0003);
    ce <= 1'b1;
    repeat (10) @(posedge clk);
    chk("ov_on", {14'h0, chon}, 16'h0002);
    chk("ov_alert", {15'h0, alert}, 16'h0001);
    op(`CMD_STATUS_BYTE, 0, 0, 16'h0000);
    chk("sb_ov", {15'h0, rv[`SB_OV_BIT]}, 16'h0001);
    op(`CMD_STATUS_VOUT, 0, 0, 16'h0000);
    chk("sv_ov", {15'h0, rv[`SV_OV_BIT]}, 16'h0001);
    op(`CMD_STATUS_WORD, 0, 1, 16'h0000);
    chk("sw_ov", {15'h0, rv[15]}, 16'h0001);
    op(`CMD_ALERT_MASK, 1, 0, 16'h0088);
    chk("ov_masked", {15'h0, alert}, 16'h0000);
    ovd <= 2'b00;
    repeat (10) @(posedge clk);
    chk("ov_latched", {14'h0, chon}, 16'h0002);
    en <= 2'b10;
    repeat (10) @(posedge clk);
    en <= 2'b11;
    repeat (10) @(posedge clk);
    chk("ov_restart", {14'h0, chon}, 16'h0003);
  endtask

  // Main sequence: reset, then each scenario in turn.
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(posedge clk);
    chk("on_at_start", {14'h0, chon}, 16'h0003);
    t_ceiling();
    t_fine();
    t_action();
    t_clamp();
    t_ov();
    test_done();
  end
endmodule

//--- dv/vout_limit_props.sv
/*
  Checker for the limit link between host end and controller end.
  Assumes it watches the signals of the one interface that joins them.
*/
`include "vout_limit_consts.svh"
module vout_limit_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic req,
  input wire logic write,
  input wire logic word,
  input wire logic [7:0] code,
  input wire logic [15:0] wdata,
  input wire logic ack,
  input wire logic err,
  input wire logic [15:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // --------------------------------------------------------------------
  // Answer shapes
  // --------------------------------------------------------------------
  // An answer to one code with a given direction and width.
  sequence s_ans(logic [7:0] c, logic w, logic wd);
    ack && code == c && write == w && word == wd;
  endsequence
  // A request that has just started and is answered one cycle later.
  sequence s_take;
    $rose(req) ##1 ack;
  endsequence

  a_ack_after_take: assert property ($rose(req) |-> s_take)
    else $error("link answer not one cycle after request");
  a_ack_one_pulse: assert property (ack |=> !ack && !req)
    else $error("link answer or request held too long");
  a_action_fixed: assert property (s_ans(`CMD_OV_ACTION, 0, 0) |-> !err && rdata == 16'h0080)
    else $error("action register not fixed");
  a_action_word_ref: assert property (s_ans(`CMD_OV_ACTION, 0, 1) |-> err)
    else $error("action word read accepted");
  a_action_write_ref: assert property (s_ans(`CMD_OV_ACTION, 1, 0) |-> err)
    else $error("action write accepted");
  a_thr_upper_zero: assert property (s_ans(`CMD_OV_THRESHOLD, 0, 1) |-> rdata[15:8] == 8'h00)
    else $error("threshold upper byte not zero");
  a_thr_write_ref: assert property (s_ans(`CMD_OV_THRESHOLD, 1, 1) |-> err)
    else $error("threshold write accepted");
  a_ceil_byte_ref: assert property (s_ans(`CMD_OUTPUT_CEILING, 1, 0) |-> err)
    else $error("ceiling byte access accepted");
  a_ceil_upper_zero: assert property (s_ans(`CMD_OUTPUT_CEILING, 0, 1) |-> rdata[15:8] == 8'h00)
    else $error("ceiling upper byte not zero");
endmodule

//--- logic/limit_host.sv
/*
  Host end: takes commands from software over APB and runs them as paged
  requests on the limit link, one at a time.
  Assumes an APB master of the usual two-phase form on the same clock.
*/
`include "vout_limit_consts.svh"
module limit_host (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  limit_link_if.host lk
);
  vout_limit_pkg::host_state_e state_reg;
  logic [15:0] wdata_reg;
  logic [15:0] rdata_reg;
  logic err_reg;
  logic done_reg;
  logic setup;
  logic start;
  logic mapped;

  // --------------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------------
  assign setup = ce & psel & ~penable;
  assign mapped = (paddr == `HOST_CMD_ADDR) | (paddr == `HOST_WDATA_ADDR)
    | (paddr == `HOST_RDATA_ADDR) | (paddr == `HOST_STAT_ADDR);
  assign start = setup & pwrite & (paddr == `HOST_CMD_ADDR)
    & (state_reg == vout_limit_pkg::HOST_IDLE);

  // Answer in the first access cycle with registered data and error.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= setup;
      pslverr <= setup & (~mapped | (pwrite & (paddr == `HOST_CMD_ADDR)
        & (state_reg != vout_limit_pkg::HOST_IDLE)) | (pwrite
        & ((paddr == `HOST_RDATA_ADDR) | (paddr == `HOST_STAT_ADDR))));
      prdata <= 32'h00000000;
      if (setup & ~pwrite) begin
        unique case (paddr)
          `HOST_WDATA_ADDR: prdata <= {16'h0000, wdata_reg};
          `HOST_RDATA_ADDR: prdata <= {16'h0000, rdata_reg};
          `HOST_STAT_ADDR: prdata <= {29'h00000000, done_reg, err_reg,
            state_reg == vout_limit_pkg::HOST_WAIT};
          default: ;
        endcase
      end
    end
  end

  // Write data register.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wdata_reg <= 16'h0000;
    end else if (setup & pwrite & (paddr == `HOST_WDATA_ADDR)) begin
      wdata_reg <= pwdata[15:0];
    end
  end

  // --------------------------------------------------------------------------
  // Link sequencer
  // --------------------------------------------------------------------------

  // Hold the request until acknowledged, then capture the answer.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= vout_limit_pkg::HOST_IDLE;
      lk.req <= 1'b0;
      lk.write <= 1'b0;
      lk.word <= 1'b0;
      lk.code <= 8'h00;
      lk.wdata <= 16'h0000;
      rdata_reg <= 16'h0000;
      err_reg <= 1'b0;
      done_reg <= 1'b0;
    end else if (ce) begin
      unique case (state_reg)
        vout_limit_pkg::HOST_IDLE: begin
          if (start) begin
            state_reg <= vout_limit_pkg::HOST_WAIT;
            lk.req <= 1'b1;
            lk.code <= pwdata[7:0];
            lk.write <= pwdata[`CTL_WRITE_BIT];
            lk.word <= pwdata[`CTL_WORD_BIT];
            lk.wdata <= wdata_reg;
            done_reg <= 1'b0;
          end
        end
        vout_limit_pkg::HOST_WAIT: begin
          if (lk.ack) begin
            state_reg <= vout_limit_pkg::HOST_IDLE;
            lk.req <= 1'b0;
            rdata_reg <= lk.rdata;
            err_reg <= lk.err;
            done_reg <= 1'b1;
          end
        end
      endcase
    end
  end
endmodule

//--- logic/limit_link_if.sv
/*
  Link between the host end and the controller end: one request held as a
  level with its fields, answered by a one-cycle acknowledge with data.
  Assumes both ends run on the same clock.
*/
interface limit_link_if;
  logic req;
  logic write;
  logic word;
  logic [7:0] code;
  logic [15:0] wdata;
  logic ack;
  logic err;
  logic [15:0] rdata;

  modport host (output req, output write, output word, output code, output wdata,
    input ack, input err, input rdata);
  modport device (input req, input write, input word, input code, input wdata,
    output ack, output err, output rdata);
endinterface

//--- logic/pin_sync.sv
/*
  Three-stage synchroniser for inputs that come from outside the clock
  domain. The output follows once the second and third stages agree.
  Assumes a clock enable that freezes all state while low.
*/
module pin_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  // Shift the pin through three stages; only agreeing bits pass on.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      level <= '0;
    end else if (ce) begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      level <= (s2_reg & s3_reg) | (level & (s2_reg | s3_reg));
    end
  end
endmodule

//--- logic/vout_limit_consts.svh
/*
  Command codes, field positions, reset values and host register offsets
  shared by the controller end and the host end of the paged limit link.
  Assumes it is included once per file by its bare name.
*/
`ifndef VOUT_LIMIT_CONSTS_SVH
`define VOUT_LIMIT_CONSTS_SVH

// --------------------------------------------------------------------------
// Command codes on the link
// --------------------------------------------------------------------------
`define CMD_PAGE 8'h00
`define CMD_OPERATION 8'h01
`define CMD_CLEAR_FAULTS 8'h03
`define CMD_ALERT_MASK 8'h1B
`define CMD_VOUT_COMMAND 8'h21
`define CMD_OUTPUT_CEILING 8'h24
`define CMD_MARGIN_HIGH 8'h25
`define CMD_MARGIN_LOW 8'h26
`define CMD_OV_THRESHOLD 8'h40
`define CMD_OV_ACTION 8'h41
`define CMD_STATUS_BYTE 8'h78
`define CMD_STATUS_WORD 8'h79
`define CMD_STATUS_VOUT 8'h7A
`define CMD_DAC_RES 8'hDD

// --------------------------------------------------------------------------
// Page codes, fixed values and reset values
// --------------------------------------------------------------------------
`define PAGE_A 8'h00
`define PAGE_B 8'h01
`define PAGE_BOTH 8'hFF
`define OV_ACTION_LATCH 8'h80
`define OV_FINE_CODE 8'hFF
`define OV_OFFSET_DEFAULT 8'h0A
`define CEILING_RESET 8'hFF
`define VOUT_RESET 8'h00
`define OPERATION_RESET 8'h80
`define MASK_RESET 8'h00
`define BYTE_ZERO 8'h00

// --------------------------------------------------------------------------
// Field positions
// --------------------------------------------------------------------------
`define SB_OV_BIT 5
`define SB_OTHER_BIT 0
`define SV_OV_BIT 7
`define SV_MINMAX_BIT 3
`define OP_ON_BIT 7
`define OP_MARGIN_HI 5
`define OP_MARGIN_LO 4
`define MARGIN_HIGH_SEL 2'h2
`define MARGIN_LOW_SEL 2'h1
`define DAC_FINE_BIT 0

// --------------------------------------------------------------------------
// Host register offsets and fields
// --------------------------------------------------------------------------
`define HOST_CMD_ADDR 12'h000
`define HOST_WDATA_ADDR 12'h004
`define HOST_RDATA_ADDR 12'h008
`define HOST_STAT_ADDR 12'h00C
`define CTL_WRITE_BIT 8
`define CTL_WORD_BIT 9
`define STAT_BUSY_BIT 0
`define STAT_ERR_BIT 1
`define STAT_DONE_BIT 2

`endif

//--- logic/vout_limit_pkg.sv
/*
  Types shared by both ends of the paged limit link.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package vout_limit_pkg;
  // Host sequencer states.
  typedef enum logic [0:0] {
    HOST_IDLE = 1'b0,
    HOST_WAIT = 1'b1
  } host_state_e;

  // One VID code.
  typedef logic [7:0] vid_t;
endpackage

//--- logic/vout_limit_regs.sv
/*
  Controller end: paged limit registers, ceiling clamp, overvoltage threshold
  readback, fixed latch-off overvoltage action, status and host alert.
  Assumes the host keeps its request steady until acknowledged, and that
  the enable pins and overvoltage comparator outputs are asynchronous.
*/
// The APB register port was left to the implementer.
// How it works
// - Page 00h A, 01h B, FFh both
// - Threshold readback: 8-bit code, upper byte zero
// - Fine resolution forces threshold to FFh
// - Coarse resolution: threshold is ceiling plus offset, capped at FFh
// - One action register shared by both channels
// - Action register read-only, fixed at 80h
// - Overvoltage latches off, sets three status bits
// - Fault or warning raises alert unless masked
// - Host clears latch by enable or ON toggle
// - Requested voltage above ceiling is clamped
// - Check command writes and margin values
// - Ceiling violation is a warning with status
// - Ceiling word access, low byte, upper zero
// - Host reads action register by byte only
`include "vout_limit_consts.svh"
module vout_limit_regs #(
  parameter logic [7:0] OV_OFFSET = `OV_OFFSET_DEFAULT
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  limit_link_if.device lk,
  input wire logic [1:0] channel_enable_pins,
  input wire logic [1:0] ov_detect,
  output logic [1:0] channel_on,
  output logic [7:0] target_a,
  output logic [7:0] target_b,
  output logic [7:0] ov_threshold_code_a,
  output logic [7:0] ov_threshold_code_b,
  output logic host_alert_out
);
  logic [1:0] enable_s, ov_s, ov_latch_reg, ov_flag_reg, warn_flag_reg;
  logic [1:0] hits, warn_event, ov_event;
  logic [7:0] page_reg, dac_resolution_select_reg, alert_mask_reg;
  vout_limit_pkg::vid_t operation_reg [2], ceiling_code_reg [2], command_reg [2];
  vout_limit_pkg::vid_t margin_hi_reg [2], margin_lo_reg [2], requested [2], threshold [2];
  logic take, wr, sel_b, rd_err;
  logic [15:0] rd_data;

  // --------------------------------------------------------------------------
  // Helpers and pin synchronisers
  // --------------------------------------------------------------------------
  // Channels addressed by a page code; zero for an unknown page.
  function automatic logic [1:0] page_hits(input logic [7:0] page);
    unique case (page)
      `PAGE_A: page_hits = 2'h1;
      `PAGE_B: page_hits = 2'h2;
      `PAGE_BOTH: page_hits = 2'h3;
      default: page_hits = 2'h0;
    endcase
  endfunction

  // Limits a code to the ceiling.
  function automatic logic [7:0] clamp(input logic [7:0] v, input logic [7:0] ceil);
    clamp = (v > ceil) ? ceil : v;
  endfunction

  // Enable pins and comparator outputs share one synchroniser.
  pin_sync #(.WIDTH(4)) pin_sync_inst (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .pin({ov_detect, channel_enable_pins}),
    .level({ov_s, enable_s})
  );

  // --------------------------------------------------------------------------
  // Request decode
  // --------------------------------------------------------------------------
  // A request is taken when it stands and no acknowledge is pending.
  assign take = ce & lk.req & ~lk.ack;
  assign wr = take & lk.write & ~rd_err;
  assign hits = page_hits(page_reg);
  assign sel_b = (page_reg == `PAGE_B);

  // Per-channel requested level, threshold and events.
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      unique case (operation_reg[i][`OP_MARGIN_HI:`OP_MARGIN_LO])
        `MARGIN_HIGH_SEL: requested[i] = margin_hi_reg[i];
        `MARGIN_LOW_SEL: requested[i] = margin_lo_reg[i];
        default: requested[i] = command_reg[i];
      endcase
      if (dac_resolution_select_reg[`DAC_FINE_BIT]) begin
        threshold[i] = `OV_FINE_CODE;
      end else if ({1'b0, ceiling_code_reg[i]} + {1'b0, OV_OFFSET} > 9'h0FF) begin
        threshold[i] = `OV_FINE_CODE;
      end else begin
        threshold[i] = ceiling_code_reg[i] + OV_OFFSET;
      end
      // Command writes above the ceiling, or a margin level above it.
      warn_event[i] = (wr & hits[i] & (lk.code == `CMD_VOUT_COMMAND)
        & (lk.wdata[7:0] > ceiling_code_reg[i]))
        | ((operation_reg[i][`OP_MARGIN_HI:`OP_MARGIN_LO] != 2'h0)
        & (requested[i] > ceiling_code_reg[i]));
      ov_event[i] = ov_s[i] & ~ov_latch_reg[i] & channel_on[i];
    end
  end

  // Read multiplexer and access checks.
  always_comb begin
    rd_data = 16'h0000;
    rd_err = 1'b0;
    unique case (lk.code)
      `CMD_PAGE: rd_data = {`BYTE_ZERO, page_reg};
      `CMD_OPERATION: rd_data = {`BYTE_ZERO, operation_reg[sel_b]};
      `CMD_CLEAR_FAULTS: rd_err = ~lk.write;
      `CMD_ALERT_MASK: rd_data = {`BYTE_ZERO, alert_mask_reg};
      `CMD_VOUT_COMMAND: rd_data = {`BYTE_ZERO, command_reg[sel_b]};
      `CMD_OUTPUT_CEILING: begin
        rd_data = {`BYTE_ZERO, ceiling_code_reg[sel_b]};
        rd_err = ~lk.word;
      end
      `CMD_MARGIN_HIGH: rd_data = {`BYTE_ZERO, margin_hi_reg[sel_b]};
      `CMD_MARGIN_LOW: rd_data = {`BYTE_ZERO, margin_lo_reg[sel_b]};
      `CMD_OV_THRESHOLD: begin
        rd_data = {`BYTE_ZERO, threshold[sel_b]};
        rd_err = lk.write | ~lk.word;
      end
      `CMD_OV_ACTION: begin
        rd_data = {`BYTE_ZERO, `OV_ACTION_LATCH};
        rd_err = lk.write | lk.word;
      end
      `CMD_STATUS_BYTE, `CMD_STATUS_WORD: begin
        rd_data[`SB_OV_BIT] = ov_flag_reg[sel_b];
        rd_data[`SB_OTHER_BIT] = warn_flag_reg[sel_b];
        rd_data[15] = (ov_flag_reg[sel_b] | warn_flag_reg[sel_b])
          & (lk.code == `CMD_STATUS_WORD);
      end
      `CMD_STATUS_VOUT: begin
        rd_data[`SV_OV_BIT] = ov_flag_reg[sel_b];
        rd_data[`SV_MINMAX_BIT] = warn_flag_reg[sel_b];
      end
      `CMD_DAC_RES: rd_data = {`BYTE_ZERO, dac_resolution_select_reg};
      default: rd_err = 1'b1;
    endcase
    if (lk.code != `CMD_PAGE && lk.code != `CMD_OV_ACTION && lk.code != `CMD_ALERT_MASK
        && lk.code != `CMD_DAC_RES && hits == 2'h0) begin
      rd_err = 1'b1;
    end
  end

  // One acknowledge cycle per taken request, with data and refusal flag.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lk.ack <= 1'b0;
      lk.err <= 1'b0;
      lk.rdata <= 16'h0000;
    end else if (ce) begin
      lk.ack <= take;
      if (take) begin
        lk.err <= rd_err;
        lk.rdata <= lk.write ? 16'h0000 : rd_data;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Shared and paged registers
  // --------------------------------------------------------------------------
  // Page, resolution select and alert mask act on both channels.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      page_reg <= `PAGE_A;
      dac_resolution_select_reg <= `BYTE_ZERO;
      alert_mask_reg <= `MASK_RESET;
    end else if (wr) begin
      if (lk.code == `CMD_PAGE) page_reg <= lk.wdata[7:0];
      if (lk.code == `CMD_DAC_RES) dac_resolution_select_reg <= lk.wdata[7:0];
      if (lk.code == `CMD_ALERT_MASK) alert_mask_reg <= lk.wdata[7:0];
    end
  end

  // Writes land on every channel that the page addresses.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 2; i++) begin
        operation_reg[i] <= `OPERATION_RESET;
        ceiling_code_reg[i] <= `CEILING_RESET;
        command_reg[i] <= `VOUT_RESET;
        margin_hi_reg[i] <= `VOUT_RESET;
        margin_lo_reg[i] <= `VOUT_RESET;
      end
    end else if (wr) begin
      for (int i = 0; i < 2; i++) begin
        if (hits[i]) begin
          unique case (lk.code)
            `CMD_OPERATION: operation_reg[i] <= lk.wdata[7:0];
            `CMD_OUTPUT_CEILING: ceiling_code_reg[i] <= lk.wdata[7:0];
            `CMD_VOUT_COMMAND: command_reg[i] <= clamp(lk.wdata[7:0],
              ceiling_code_reg[i]);
            `CMD_MARGIN_HIGH: margin_hi_reg[i] <= lk.wdata[7:0];
            `CMD_MARGIN_LOW: margin_lo_reg[i] <= lk.wdata[7:0];
            default: ;
          endcase
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Overvoltage latch, status and outputs
  // --------------------------------------------------------------------------
  // Each channel latches off on its own fault; pin or ON low clears it.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ov_latch_reg <= 2'h0;
    end else if (ce) begin
      for (int i = 0; i < 2; i++) begin
        if (ov_event[i]) begin
          ov_latch_reg[i] <= 1'b1;
        end else if (~enable_s[i] | ~operation_reg[i][`OP_ON_BIT]) begin
          ov_latch_reg[i] <= 1'b0;
        end
      end
    end
  end

  // Sticky flags; a new event in the clearing cycle wins.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ov_flag_reg <= 2'h0;
      warn_flag_reg <= 2'h0;
    end else if (ce) begin
      for (int i = 0; i < 2; i++) begin
        if (ov_event[i]) begin
          ov_flag_reg[i] <= 1'b1;
        end else if (wr & hits[i] & ((lk.code == `CMD_CLEAR_FAULTS)
            | ((lk.code == `CMD_STATUS_VOUT) & lk.wdata[`SV_OV_BIT]))) begin
          ov_flag_reg[i] <= 1'b0;
        end
        if (warn_event[i]) begin
          warn_flag_reg[i] <= 1'b1;
        end else if (wr & hits[i] & ((lk.code == `CMD_CLEAR_FAULTS)
            | ((lk.code == `CMD_STATUS_VOUT) & lk.wdata[`SV_MINMAX_BIT]))) begin
          warn_flag_reg[i] <= 1'b0;
        end
      end
    end
  end

  // Power stage controls, clamped targets, thresholds and alert.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      channel_on <= 2'h0;
      target_a <= `VOUT_RESET;
      target_b <= `VOUT_RESET;
      ov_threshold_code_a <= `OV_FINE_CODE;
      ov_threshold_code_b <= `OV_FINE_CODE;
      host_alert_out <= 1'b0;
    end else if (ce) begin
      for (int i = 0; i < 2; i++) begin
        channel_on[i] <= enable_s[i] & operation_reg[i][`OP_ON_BIT]
          & ~ov_latch_reg[i] & ~ov_event[i];
      end
      target_a <= clamp(requested[0], ceiling_code_reg[0]);
      target_b <= clamp(requested[1], ceiling_code_reg[1]);
      ov_threshold_code_a <= threshold[0];
      ov_threshold_code_b <= threshold[1];
      host_alert_out <= |((ov_flag_reg & {2{~alert_mask_reg[`SV_OV_BIT]}})
        | (warn_flag_reg & {2{~alert_mask_reg[`SV_MINMAX_BIT]}}));
    end
  end
endmodule
